//--- include/ses_defs.svh
// Operation
// - Reading a live state register returns the present condition bits and changes nothing.
// - A latched event register keeps every event since its last read, and reading it clears it.
// - With a falling-edge select bit set, a one-to-zero change of that live bit sets the event bit.
// - With a rising-edge select bit set, a zero-to-one change of that live bit sets the event bit.
// - The operation summary mask picks event bits into the operation summary at status byte bit 7.
// - The device raises a service request from the status byte that carries the group summaries.
// - The questionable summary rises when any enabled event bit is true, and the rise goes upward.
// - Live state, event, mask and edge-select parts are 16 bits, values 0 to 65535.
// - Per-channel parts are picked by channel index 1 or 2, and no other index is used.
// - The questionable live state register shows whether the instrument state is questionable.
`ifndef SES_DEFS_SVH
`define SES_DEFS_SVH

`define SES_WIDTH        16
// Command group codes
`define SES_GRP_OPER     1'h0
`define SES_GRP_QUEST    1'h1
// Set index: instrument level, then channel 1 and 2
`define SES_SET_INST     2'h0
`define SES_SET_CH_LAST  2'h2
// Part codes
`define SES_PART_LIVE    3'h0
`define SES_PART_MASK    3'h1
`define SES_PART_EVENT   3'h2
`define SES_PART_FALL    3'h3
`define SES_PART_RISE    3'h4
// Status byte bit positions
`define SES_STB_QUEST    3
`define SES_STB_OPER     7
// Reset values
`define SES_RST_MASK     16'h0000
`define SES_RST_FALL     16'h0000
`define SES_RST_RISE     16'hFFFF
`define SES_RST_LIVE     16'h0000
`define SES_RST_EVENT    16'h0000

`endif

//--- include/ses_pkg.sv
package ses_pkg;

  typedef logic [15:0] ses_word_t;

  // Register set for one group at one level
  typedef struct packed {
    ses_word_t live;
    ses_word_t mask;
    ses_word_t event_bits;
    ses_word_t fall_sel;
    ses_word_t rise_sel;
  } ses_set_t;

  // Whole state: two groups by three levels plus answer and summary history
  typedef struct packed {
    ses_set_t [1:0][2:0] sets;
    logic               quest_sum;
    logic               rsp_valid;
    ses_word_t          rsp_data;
  } ses_state_t;

endpackage

//--- rtl/ses_status_event_summary.sv
`timescale 1ns/10ps
`include "ses_defs.svh"

module ses_status_event_summary (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Condition sources, one port per group indexed by level, level 0 is the instrument
  input  wire logic [15:0] cond_oper_in [0:2],
  input  wire logic [15:0] cond_quest_in [0:2],
  // Controller command port
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_write_in,
  input  wire logic        cmd_group_in,
  input  wire logic [1:0]  cmd_level_in,
  input  wire logic [2:0]  cmd_part_in,
  input  wire logic [15:0] cmd_data_in,
  // Answer to queries
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_data_out,
  // Status byte and service request
  input  wire logic [7:0]  srq_enable_in,
  output logic [7:0]       status_byte_out,
  output logic             srq_out,
  output logic             quest_rise_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Summary of one set: any enabled event bit
  function automatic logic set_summary(input ses_pkg::ses_set_t s);
    set_summary = |(s.event_bits & s.mask);
  endfunction

  // Per-channel index must be 1 or 2, level 0 is the instrument
  function automatic logic level_ok(input logic [1:0] lvl);
    level_ok = (lvl <= `SES_SET_CH_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Registered state and its next value
  ses_pkg::ses_state_t state_reg;
  ses_pkg::ses_state_t state_next;
  // Conditions as the edge filter sees them, one summary per group and level
  logic [15:0]         cond_now [0:1][0:2];
  logic                sum_now  [0:1][0:2];
  logic                oper_sum;
  logic                quest_sum;

  // Live conditions; instrument bits 1 and 2 carry the channel summaries
  // Channel summaries come from registered events, so the instrument level
  // sees a channel event one edge after the channel latched it.
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      for (int l = 0; l < 3; l++) begin
        sum_now[g][l] = set_summary(state_reg.sets[g][l]);
      end
    end
    for (int l = 0; l < 3; l++) begin
      cond_now[0][l] = cond_oper_in[l];
      cond_now[1][l] = cond_quest_in[l];
    end
    // Instrument pins 1 and 2 are overridden, so they are ignored
    for (int g = 0; g < 2; g++) begin
      cond_now[g][0][1] = sum_now[g][1];
      cond_now[g][0][2] = sum_now[g][2];
    end
  end

  // Group summaries taken from the instrument-level sets
  assign oper_sum  = sum_now[0][0];
  assign quest_sum = sum_now[1][0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Per set and cycle: writes, then the read-clear, then new edges.
  // Setting after the clear keeps an edge that lands in the read cycle
  // for the next read instead of losing it.
  // Live always takes the present condition, so it lags the pins one edge.
  always_comb begin
    ses_pkg::ses_set_t s;
    logic              hit;
    logic [15:0]       edges;
    logic [1:0]        rd_level;
    s          = '0;
    hit        = 1'b0;
    edges      = '0;
    // Illegal level never reaches the index, so no out-of-range select
    rd_level   = level_ok(cmd_level_in) ? cmd_level_in : `SES_SET_INST;
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    state_next.quest_sum = quest_sum;
    for (int g = 0; g < 2; g++) begin
      for (int l = 0; l < 3; l++) begin
        s   = state_reg.sets[g][l];
        hit = cmd_valid_in && (cmd_group_in == g[0]) && level_ok(cmd_level_in)
              && (cmd_level_in == l[1:0]);
        // Writes to the settable parts; live and event are read only
        if (hit && cmd_write_in) begin
          unique case (cmd_part_in)
            `SES_PART_MASK:  s.mask     = cmd_data_in;
            `SES_PART_FALL:  s.fall_sel = cmd_data_in;
            `SES_PART_RISE:  s.rise_sel = cmd_data_in;
            default:         s = s;
          endcase
        end
        // Read of the event part empties it before new edges land
        if (hit && !cmd_write_in && cmd_part_in == `SES_PART_EVENT) begin
          s.event_bits = '0;
        end
        // Edge filter; a new edge in the read cycle survives the clear
        edges = (s.rise_sel & cond_now[g][l] & ~state_reg.sets[g][l].live)
              | (s.fall_sel & ~cond_now[g][l] & state_reg.sets[g][l].live);
        s.event_bits = s.event_bits | edges;
        s.live       = cond_now[g][l];
        state_next.sets[g][l] = s;
      end
    end
    // Query answer; out-of-range index answers zero
    if (cmd_valid_in && !cmd_write_in) begin
      state_next.rsp_valid = 1'b1;
      state_next.rsp_data  = '0;
      if (level_ok(cmd_level_in)) begin
        s = state_reg.sets[cmd_group_in][rd_level];
        unique case (cmd_part_in)
          `SES_PART_LIVE:  state_next.rsp_data = s.live;
          `SES_PART_MASK:  state_next.rsp_data = s.mask;
          `SES_PART_EVENT: state_next.rsp_data = s.event_bits;
          `SES_PART_FALL:  state_next.rsp_data = s.fall_sel;
          `SES_PART_RISE:  state_next.rsp_data = s.rise_sel;
          default:         state_next.rsp_data = '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset; rising selects start all ones so a condition that
  // comes up after reset is latched without any setup by the controller
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
      for (int g = 0; g < 2; g++) begin
        for (int l = 0; l < 3; l++) begin
          state_reg.sets[g][l].live       <= `SES_RST_LIVE;
          state_reg.sets[g][l].mask       <= `SES_RST_MASK;
          state_reg.sets[g][l].event_bits <= `SES_RST_EVENT;
          state_reg.sets[g][l].fall_sel   <= `SES_RST_FALL;
          state_reg.sets[g][l].rise_sel   <= `SES_RST_RISE;
        end
      end
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Status byte carries both group summaries; other bits stay low
  always_comb begin
    status_byte_out                 = 8'h00;
    status_byte_out[`SES_STB_OPER]  = oper_sum;
    status_byte_out[`SES_STB_QUEST] = quest_sum;
  end

  // Service request is a level; reading the events is what drops it
  assign srq_out        = |(status_byte_out & srq_enable_in);
  assign quest_rise_out = quest_sum & ~state_reg.quest_sum;
  assign rsp_valid_out  = state_reg.rsp_valid;
  assign rsp_data_out   = state_reg.rsp_data;

endmodule

//--- testbench/ses_ctrl_model.sv
`timescale 1ns/10ps
// Controller side: one command per call, strobe held one cycle
module ses_ctrl_model (
  input  wire logic  clk_in,
  output logic       cmd_valid_out,
  output logic       cmd_write_out,
  output logic       cmd_group_out,
  output logic [1:0] cmd_level_out,
  output logic [2:0] cmd_part_out,
  output logic [15:0] cmd_data_out
);
  initial {cmd_valid_out, cmd_write_out, cmd_group_out, cmd_level_out, cmd_part_out, cmd_data_out} = '0;
  // Level 3 only when a refusal is wanted data is 16 bits by type
  task automatic send(input logic w, g, input logic [1:0] l, input logic [2:0] p, input logic [15:0] d);
    @(negedge clk_in);
    {cmd_valid_out, cmd_write_out, cmd_group_out, cmd_level_out, cmd_part_out, cmd_data_out} = {1'b1, w, g, l, p, d};
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_data_out = ~d; // Stale data never looks valid
  endtask
endmodule

//--- testbench/ses_status_event_summary_sva.sv
`timescale 1ns/10ps
module ses_status_event_summary_sva (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        cmd_valid_in,
  input wire logic        cmd_write_in,
  input wire logic        cmd_group_in,
  input wire logic [1:0]  cmd_level_in,
  input wire logic [2:0]  cmd_part_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic        rsp_valid_out,
  input wire logic [15:0] rsp_data_out,
  input wire logic [7:0]  srq_enable_in,
  input wire logic [7:0]  status_byte_out,
  input wire logic        srq_out,
  input wire logic        quest_rise_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Query strobe
  logic q;
  assign q = cmd_valid_in && !cmd_write_in;
  a_query_gets_answer: assert property (q |=> rsp_valid_out) else $error("query got no answer");
  a_no_stray_answer: assert property (!q |=> !rsp_valid_out) else $error("answer without query");
  a_rsp_data_holds: assert property (!q |=> $stable(rsp_data_out)) else $error("answer data moved");
  a_bad_level_zero: assert property (q && cmd_level_in == 2'h3 |=> rsp_data_out == 16'h0000)
    else $error("bad channel answered");
  a_mask_read_back: assert property (cmd_valid_in && cmd_write_in && cmd_part_in == 3'h1 && cmd_level_in != 2'h3
    ##2 (q && cmd_part_in == 3'h1 && cmd_level_in == $past(cmd_level_in, 2) && cmd_group_in == $past(cmd_group_in, 2))
    |=> rsp_data_out == $past(cmd_data_in, 3)) else $error("mask read back wrong");
  a_srq_from_byte: assert property (srq_out == |(status_byte_out & srq_enable_in)) else $error("srq wrong");
  a_byte_spare_zero: assert property ((status_byte_out & 8'h77) == 8'h00) else $error("spare bit set");
  a_rise_one_cycle: assert property (quest_rise_out |=> !quest_rise_out) else $error("rise too long");
  a_reset_byte_clear: assert property ($fell(rst_in) |-> status_byte_out == 8'h00 && !srq_out)
    else $error("status byte after reset");
  c_answer: cover property (rsp_valid_out);
  c_oper_sum: cover property (status_byte_out[7] && srq_out);
  c_quest_rise: cover property (quest_rise_out);
endmodule
bind ses_status_event_summary ses_status_event_summary_sva chk_u (.*);

//--- testbench/status_event_summary_tb.sv
`timescale 1ns/10ps
module status_event_summary_tb;
  logic        clk_in = 1'b0, rst_in = 1'b1, rsp_valid, srq, qrise, v, w, g, rose = 1'b0;
  logic [15:0] co [0:2] = '{default: 16'h0000}, cq [0:2] = '{default: 16'h0000}, d, rsp;
  logic [1:0]  l;
  logic [2:0]  p;
  logic [7:0]  srq_en = 8'h00, stb;
  int          err_count = 0, cmp_count = 0, cyc = 0;
  initial forever #2 clk_in = ~clk_in;
  ses_ctrl_model ctrl_u (.clk_in(clk_in), .cmd_valid_out(v), .cmd_write_out(w), .cmd_group_out(g),
    .cmd_level_out(l), .cmd_part_out(p), .cmd_data_out(d));
  ses_status_event_summary dut_u (.clk_in(clk_in), .rst_in(rst_in), .cond_oper_in(co), .cond_quest_in(cq),
    .cmd_valid_in(v), .cmd_write_in(w), .cmd_group_in(g), .cmd_level_in(l), .cmd_part_in(p), .cmd_data_in(d),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp), .srq_enable_in(srq_en), .status_byte_out(stb),
    .srq_out(srq), .quest_rise_out(qrise));
  // Hang guard and rise pulse catcher
  always @(posedge clk_in) begin
    cyc++;
    if (qrise === 1'b1) rose <= 1'b1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop;
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic qy(input logic gr, input logic [1:0] lv, input logic [2:0] pt, input logic [15:0] exp);
    ctrl_u.send(1'b0, gr, lv, pt, 16'h0000);
    chk("rsp_valid", 16'(rsp_valid), 16'h0001);
    chk("rsp_data", rsp, exp);
  endtask
  task automatic t_mask;
    for (int i = 0; i < 3; i++) begin
      ctrl_u.send(1'b1, 1'b1, i[1:0], 3'h1, 16'hFFFF - 16'(i));
      qy(1'b1, i[1:0], 3'h1, 16'hFFFF - 16'(i));
    end
    qy(1'b1, 2'h3, 3'h1, 16'h0000);
    $display("t_mask done");
  endtask
  // Rise picked on bit 0 only, fall on bit 1 only
  task automatic t_edges;
    ctrl_u.send(1'b1, 1'b0, 2'h2, 3'h4, 16'h0001);
    ctrl_u.send(1'b1, 1'b0, 2'h2, 3'h3, 16'h0002);
    co[2] = 16'h0003;
    repeat (3) @(negedge clk_in);
    co[2] = 16'h0000;
    repeat (3) @(negedge clk_in);
    qy(1'b0, 2'h2, 3'h2, 16'h0003);
    qy(1'b0, 2'h2, 3'h2, 16'h0000);
    qy(1'b0, 2'h2, 3'h0, 16'h0000);
    $display("t_edges done");
  endtask
  // Select read-back, reset selects, refused writes and part codes
  task automatic t_parts;
    qy(1'b0, 2'h2, 3'h3, 16'h0002);
    qy(1'b0, 2'h2, 3'h4, 16'h0001);
    qy(1'b1, 2'h1, 3'h4, 16'hFFFF);
    qy(1'b0, 2'h0, 3'h3, 16'h0000);
    ctrl_u.send(1'b1, 1'b0, 2'h2, 3'h0, 16'hFFFF);
    ctrl_u.send(1'b1, 1'b0, 2'h2, 3'h2, 16'hFFFF);
    qy(1'b0, 2'h2, 3'h0, 16'h0000);
    qy(1'b0, 2'h2, 3'h2, 16'h0000);
    qy(1'b0, 2'h2, 3'h5, 16'h0000);
    $display("t_parts done");
  endtask
  // Channel 1 event climbs to the status byte
  task automatic t_chain;
    srq_en = 8'h80;
    ctrl_u.send(1'b1, 1'b0, 2'h1, 3'h1, 16'h0001);
    ctrl_u.send(1'b1, 1'b0, 2'h0, 3'h1, 16'h0002);
    co[1] = 16'h0001;
    repeat (6) @(negedge clk_in);
    chk("status_byte", 16'(stb), 16'h0080);
    chk("srq", 16'(srq), 16'h0001);
    qy(1'b0, 2'h0, 3'h0, 16'h0002);
    qy(1'b0, 2'h0, 3'h2, 16'h0002);
    chk("status_byte", 16'(stb), 16'h0000);
    $display("t_chain done");
  endtask
  task automatic t_quest;
    ctrl_u.send(1'b1, 1'b1, 2'h0, 3'h1, 16'h0001);
    cq[0] = 16'h0001;
    repeat (4) @(negedge clk_in);
    chk("status_byte", 16'(stb), 16'h0008);
    chk("quest_rise", 16'(rose), 16'h0001);
    qy(1'b1, 2'h0, 3'h0, 16'h0001);
    $display("t_quest done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset, then each scenario in turn
  initial begin
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    t_mask;
    t_edges;
    t_parts;
    t_chain;
    t_quest;
    report_and_stop;
  end
endmodule
